// [verilog/cpps_pkg.sv]
`default_nettype none
// ==========================================================
// Shared constants for the charger power path sequencer
package cpps_pkg;
   // ==========================================================
   // Clock and time base
   localparam int unsigned CPPS_CLK_MHZ = 100; // Oscillator rate in MHz
   localparam int unsigned CPPS_DETECT_MS = 700; // Adapter qualification delay, ms
   localparam int unsigned CPPS_OC_MS = 10; // Extra overcurrent interval, ms
   localparam int unsigned CPPS_DEAD_US = 10; // Selector dead time, us
   localparam int unsigned CPPS_STEP_US = 1700; // Soft-start step length, us (1.7 ms)
   // Derived cycle counts; all are least times and divide exactly
   localparam int unsigned CPPS_DETECT_CYC = CPPS_DETECT_MS * 1000 * CPPS_CLK_MHZ;
   localparam int unsigned CPPS_OC_CYC = CPPS_OC_MS * 1000 * CPPS_CLK_MHZ;
   localparam int unsigned CPPS_DEAD_CYC = CPPS_DEAD_US * CPPS_CLK_MHZ;
   localparam int unsigned CPPS_STEP_CYC = CPPS_STEP_US * CPPS_CLK_MHZ;

   // ==========================================================
   // Soft-start and cell count encodings
   localparam logic [3:0] CPPS_STEP_MAX = 4'h8; // Number of equal current steps
   localparam logic [3:0] CPPS_STEP_MIN = 4'h1; // First step after enable
   localparam logic [2:0] CPPS_CELLS_FLOAT = 3'h2; // Pin left floating
   localparam logic [2:0] CPPS_CELLS_GND = 3'h3; // Pin tied to analog ground
   localparam logic [2:0] CPPS_CELLS_REF = 3'h4; // Pin tied to reference output

   // ==========================================================
   // Register map, byte addresses, and field positions
   localparam logic [3:0] CPPS_STATUS_OFS = 4'h0; // Read-only status
   localparam logic [3:0] CPPS_CONTROL_OFS = 4'h4; // Read/write control
   localparam logic [3:0] CPPS_LEVEL_OFS = 4'h8; // Read-only soft-start level
   localparam logic [31:0] CPPS_CONTROL_RST = 32'h0000_0000; // Control after reset
   localparam int unsigned CPPS_CTL_INHIBIT_BIT = 0; // Software charge inhibit

   // ==========================================================
   // Selector states
   typedef enum logic [1:0] {
      CPPS_SEL_BAT = 2'b00, // Battery feeds system
      CPPS_SEL_TO_AC = 2'b01, // Both off, heading to adapter
      CPPS_SEL_AC = 2'b10, // Adapter feeds system
      CPPS_SEL_TO_BAT = 2'b11 // Both off, heading to battery
   } cpps_sel_t;
endpackage : cpps_pkg
`default_nettype wire

// [verilog/cpps_timer.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Saturating interval timer, cleared while run is low
module cpps_timer #(
   parameter int unsigned COUNT = 1000 // Cycles until done
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Control and result
   input wire logic run,
   output logic done
);
   localparam int unsigned W = (COUNT > 1) ? $clog2(COUNT) : 1; // Counter width
   localparam logic [W-1:0] LAST = W'(COUNT - 1); // Final count
   logic [W-1:0] cnt_reg; // Elapsed cycles

   // ==========================================================
   // Count while qualified, restart as soon as run drops
   always_ff @(posedge clock) begin
      if (rst || !run) begin
         cnt_reg <= '0;
         done <= 1'b0;
      end else if (cnt_reg == LAST) begin
         done <= 1'b1; // Hold until run falls
      end else begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end
endmodule : cpps_timer
`default_nettype wire

// [verilog/cpps_top.sv]
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Three-level pin gives 2, 3 or 4 cells
// - Supply below 4 V keeps everything disabled
// - Low sense: partial bias, drivers, monitor grounded
// - Sense above 0.6 V: full bias, monitor valid
// - Above 2.4 V, 700 ms later signal good
// - Battery switch on until adapter detected
// - Charge only with all enable conditions met
// - Also headroom, delays done, reference valid
// - Battery off before adapter on, never both
// - Changeover after delay, needs 185 mV headroom
// - Both off 10 us before adapter on
// - Back to battery within 285 mV, dead time
// - Drive high is off, low is on
// - Turn-off fast, turn-on deferred and slow
// - Ramp charge current in 8 equal steps
// - Each step lasts about 1.7 ms
// - Reduce charge current while input over limit
// - Adjust pin at regulator selects default target
module cpps_top #(
   parameter int unsigned DETECT_CYC = cpps_pkg::CPPS_DETECT_CYC, // Adapter delay
   parameter int unsigned OC_CYC = cpps_pkg::CPPS_OC_CYC, // Overcurrent interval
   parameter int unsigned STEP_CYC = cpps_pkg::CPPS_STEP_CYC // Soft-start step
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Comparator results from the analog front end
   input wire logic supply_ok, // input_supply above 4 V
   input wire logic adapter_sense_above_low, // adapter_sense above 0.6 V
   input wire logic adapter_sense_above_det, // adapter_sense above 2.4 V
   input wire logic supply_above_battery, // input_supply over battery by 185 mV
   input wire logic adapter_side_near_battery, // adapter_side_sense within 285 mV
   input wire logic adapter_overvoltage,
   input wire logic thermal_shutdown,
   input wire logic thermistor_sense_ok, // Inside temperature window
   input wire logic ratio_reference_ok, // ratio_reference above 2.4 V
   input wire logic input_over_limit, // Input current above input_limit_set
   input wire logic voltage_adjust_at_regulator,
   input wire logic cells_above_high, // Pin above high threshold
   input wire logic cells_below_low, // Pin below low threshold
   // Host logic input
   input wire logic charge_enable_n,
   // Bias and monitor enables
   output logic bias_partial_en,
   output logic bias_full_en,
   output logic gate_drive_regulator_en,
   output logic reference_en,
   output logic input_current_monitor_en,
   // Selector gate drives and status
   output logic adapter_switch_drive_n,
   output logic battery_switch_drive_n,
   output logic adapter_good_n,
   // Charger control
   output logic charge_en,
   output logic [3:0] charge_current_step,
   output logic input_power_limiting,
   output logic [2:0] cell_count,
   output logic voltage_target_default
);
   import cpps_pkg::*;

   // ==========================================================
   // Declarations
   cpps_sel_t sel_reg; // Selector state
   cpps_sel_t sel_next; // Selector next state
   logic [31:0] control_reg; // Software control word
   logic detect_run; // Adapter valid and biased
   logic detect_done; // 700 ms elapsed
   logic oc_done; // Extra 10 ms elapsed
   logic dead_done; // Dead time elapsed
   logic step_done; // One soft-start step elapsed
   logic charge_ok; // All charge conditions met now
   logic step_run; // Step timer qualifier

   // Three-level pin decode, used by the output and status paths
   function automatic logic [2:0] cpps_cells(input logic hi, input logic lo);
      if (hi) begin
         cpps_cells = CPPS_CELLS_REF;
      end else if (lo) begin
         cpps_cells = CPPS_CELLS_GND;
      end else begin
         cpps_cells = CPPS_CELLS_FLOAT; // Floating sits mid-rail
      end
   endfunction : cpps_cells

   // ==========================================================
   // Interval timers on the local oscillator
   // Adapter must stay above threshold the whole interval
   assign detect_run = supply_ok && adapter_sense_above_low && adapter_sense_above_det;
   cpps_timer #(.COUNT(DETECT_CYC)) u_detect_timer (
      .clock(clock),
      .rst(rst),
      .run(detect_run),
      .done(detect_done)
   );
   // Overcurrent interval follows the detection delay
   cpps_timer #(.COUNT(OC_CYC)) u_oc_timer (
      .clock(clock),
      .rst(rst),
      .run(detect_run && detect_done),
      .done(oc_done)
   );
   // Dead time runs in both break states
   cpps_timer #(.COUNT(CPPS_DEAD_CYC)) u_dead_timer (
      .clock(clock),
      .rst(rst),
      .run(sel_reg == CPPS_SEL_TO_AC || sel_reg == CPPS_SEL_TO_BAT),
      .done(dead_done)
   );
   // Step timer restarts after each step; one idle cycle per step is fine
   assign step_run = charge_en && !step_done;
   cpps_timer #(.COUNT(STEP_CYC)) u_step_timer (
      .clock(clock),
      .rst(rst),
      .run(step_run),
      .done(step_done)
   );

   // ==========================================================
   // Bias staging
   always_ff @(posedge clock) begin
      if (rst) begin
         bias_partial_en <= 1'b0;
         bias_full_en <= 1'b0;
         gate_drive_regulator_en <= 1'b0;
         reference_en <= 1'b0;
         input_current_monitor_en <= 1'b0;
      end else begin
         bias_partial_en <= supply_ok;
         // Monitor stays grounded until the sense clears its low threshold
         bias_full_en <= supply_ok && adapter_sense_above_low;
         gate_drive_regulator_en <= supply_ok && adapter_sense_above_low;
         reference_en <= supply_ok && adapter_sense_above_low;
         input_current_monitor_en <= supply_ok && adapter_sense_above_low;
      end
   end

   // ==========================================================
   // Adapter good status, cleared at once on adapter loss
   always_ff @(posedge clock) begin
      if (rst) begin
         adapter_good_n <= 1'b1;
      end else begin
         adapter_good_n <= !(detect_done && detect_run);
      end
   end

   // ==========================================================
   // Selector state machine; break-before-make
   always_comb begin
      sel_next = sel_reg;
      unique case (sel_reg)
         CPPS_SEL_BAT: begin
            // Wait for delay and headroom before leaving the battery
            if (detect_done && detect_run && supply_above_battery) begin
               sel_next = CPPS_SEL_TO_AC;
            end
         end
         CPPS_SEL_TO_AC: begin
            if (!detect_run) begin
               sel_next = CPPS_SEL_TO_BAT; // Adapter vanished mid-break
            end else if (dead_done) begin
               sel_next = CPPS_SEL_AC;
            end
         end
         CPPS_SEL_AC: begin
            // Hold the adapter until its side has sagged near the battery
            if (!detect_run && adapter_side_near_battery) begin
               sel_next = CPPS_SEL_TO_BAT;
            end
         end
         CPPS_SEL_TO_BAT: begin
            if (dead_done) begin
               sel_next = CPPS_SEL_BAT;
            end
         end
      endcase
      if (!supply_ok) begin
         sel_next = CPPS_SEL_BAT; // Lockout returns to the default path
      end
   end
   // Selector state register
   always_ff @(posedge clock) begin
      if (rst) begin
         sel_reg <= CPPS_SEL_BAT;
      end else begin
         sel_reg <= sel_next;
      end
   end

   // ==========================================================
   // Gate drives: high pulls gate to the source rail (off), low
   // asks the regulator for 6 V below it (on). Taken from the next
   // state, so a switch drops in the same edge its state is left,
   // while turn-on waits out the whole dead time.
   always_ff @(posedge clock) begin
      if (rst) begin
         adapter_switch_drive_n <= 1'b1;
         battery_switch_drive_n <= 1'b1;
      end else begin
         adapter_switch_drive_n <= !(supply_ok && sel_next == CPPS_SEL_AC);
         battery_switch_drive_n <= !(supply_ok && sel_next == CPPS_SEL_BAT);
      end
   end

   // ==========================================================
   // Charge qualification
   assign charge_ok = !charge_enable_n && supply_ok && detect_run && !adapter_overvoltage
      && !thermal_shutdown && thermistor_sense_ok
      && supply_above_battery && oc_done && ratio_reference_ok
      && !control_reg[CPPS_CTL_INHIBIT_BIT];
   // Enable register; drops the cycle after any condition fails
   always_ff @(posedge clock) begin
      if (rst) begin
         charge_en <= 1'b0;
      end else begin
         charge_en <= charge_ok;
      end
   end

   // ==========================================================
   // Soft-start level; a fresh ramp on every enable
   always_ff @(posedge clock) begin
      if (rst) begin
         charge_current_step <= 4'h0;
         input_power_limiting <= 1'b0;
      end else begin
         input_power_limiting <= charge_en && input_over_limit;
         if (!charge_en) begin
            charge_current_step <= charge_ok ? CPPS_STEP_MIN : 4'h0;
         end else if (step_done && input_over_limit) begin
            // Back off one step at a time; never below the first step
            if (charge_current_step > CPPS_STEP_MIN) begin
               charge_current_step <= charge_current_step - 1'b1;
            end
         end else if (step_done && charge_current_step < CPPS_STEP_MAX) begin
            charge_current_step <= charge_current_step + 1'b1;
         end
      end
   end

   // ==========================================================
   // Cell count and voltage target selection
   always_ff @(posedge clock) begin
      if (rst) begin
         cell_count <= CPPS_CELLS_FLOAT;
         voltage_target_default <= 1'b0;
      end else begin
         cell_count <= cpps_cells(cells_above_high, cells_below_low);
         voltage_target_default <= voltage_adjust_at_regulator;
      end
   end

   // ==========================================================
   // Avalon-MM slave: one wait state, then the answer
   always_ff @(posedge clock) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         // Low for exactly one cycle per request
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      end
   end

   // Read data captured with the wait release; unmapped reads as zero
   always_ff @(posedge clock) begin
      if (rst) begin
         avs_readdata <= 32'h0;
      end else if (avs_read && avs_waitrequest) begin
         unique case (avs_address)
            CPPS_STATUS_OFS: begin
               avs_readdata <= {19'h0, bias_full_en, input_power_limiting, cell_count,
                  charge_current_step, sel_reg, charge_en, !adapter_good_n};
            end
            CPPS_CONTROL_OFS: begin
               avs_readdata <= control_reg;
            end
            CPPS_LEVEL_OFS: begin
               avs_readdata <= {28'h0, charge_current_step};
            end
            default: begin
               avs_readdata <= 32'h0;
            end
         endcase
      end
   end

   // Control writes land one edge after the wait ends, while waitrequest is low
   always_ff @(posedge clock) begin
      if (rst) begin
         control_reg <= CPPS_CONTROL_RST;
      end else if (avs_write && !avs_waitrequest && avs_address == CPPS_CONTROL_OFS) begin
         for (int i = 0; i < 4; i++) begin
            if (avs_byteenable[i]) begin
               control_reg[i*8 +: 8] <= avs_writedata[i*8 +: 8];
            end
         end
      end
   end

   // ==========================================================
   // Assertions
   sequence s_both_off;
      adapter_switch_drive_n && battery_switch_drive_n;
   endsequence
   sequence s_enter_to_ac;
      sel_reg == CPPS_SEL_TO_AC && $past(sel_reg) == CPPS_SEL_BAT;
   endsequence
   property p_cells;
      @(posedge clock) disable iff (rst)
      (cells_above_high |=> cell_count == 3'h4) and (!cells_above_high && cells_below_low |=> cell_count == 3'h3);
   endproperty
   a_cells: assert property (p_cells) else $error("cell count decode wrong");
   property p_disabled;
      @(posedge clock) disable iff (rst)
      !supply_ok |=> !bias_partial_en && !charge_en && adapter_good_n && adapter_switch_drive_n;
   endproperty
   a_disabled: assert property (p_disabled) else $error("active under lockout");
   property p_partial;
      @(posedge clock) disable iff (rst)
      supply_ok && !adapter_sense_above_low |=> bias_partial_en && !bias_full_en && !input_current_monitor_en;
   endproperty
   a_partial: assert property (p_partial) else $error("partial bias wrong");
   property p_full;
      @(posedge clock) disable iff (rst)
      supply_ok && adapter_sense_above_low |=> bias_full_en && gate_drive_regulator_en && input_current_monitor_en;
   endproperty
   a_full: assert property (p_full) else $error("full bias missing");
   property p_bbm;
      @(posedge clock) disable iff (rst)
      adapter_switch_drive_n || battery_switch_drive_n;
   endproperty
   a_bbm: assert property (p_bbm) else $error("both switches on");
   property p_dead;
      @(posedge clock) disable iff (rst)
      s_enter_to_ac |-> s_both_off [*8];
   endproperty
   a_dead: assert property (p_dead) else $error("dead time too short");
   property p_charge_gate;
      @(posedge clock) disable iff (rst)
      charge_en |-> $past(!charge_enable_n && !thermal_shutdown && !adapter_overvoltage && oc_done);
   endproperty
   a_charge_gate: assert property (p_charge_gate) else $error("charge without qualification");
   property p_soft;
      @(posedge clock) disable iff (rst)
      $rose(charge_en) |-> charge_current_step == 4'h1 ##1 charge_current_step == 4'h1;
   endproperty
   a_soft: assert property (p_soft) else $error("soft-start not at first step");
   property p_loss;
      @(posedge clock) disable iff (rst)
      !adapter_sense_above_det |=> adapter_good_n && !charge_en;
   endproperty
   a_loss: assert property (p_loss) else $error("adapter loss not handled");
endmodule : cpps_top
`default_nettype wire

// [tb/cpps_far_side.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Far side of the selector: system node sags after unplug
module cpps_far_side #(
   parameter int unsigned DECAY = 30 // Cycles for the node to sag
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Adapter presence
   input wire logic adapter_present,
   // Comparator seen by the device
   output logic adapter_side_near_battery
);
   int unsigned sag_reg; // Cycles since unplug
   // Bulk capacitance holds the node up for a while
   always_ff @(posedge clock) begin
      if (rst || adapter_present) begin
         sag_reg <= 0;
      end else if (sag_reg < DECAY) begin
         sag_reg <= sag_reg + 1;
      end
   end
   // Never near while an adapter is plugged in
   assign adapter_side_near_battery = !adapter_present && (sag_reg >= DECAY);
endmodule : cpps_far_side
`default_nettype wire

// [tb/cpps_top_test.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end
`define WAITC(c, lim) begin n = 0; while (!(c) && n < (lim)) begin @(posedge clock); n++; end \
   if (!(c)) begin err_count++; wrap_up(); end end
// ==========================================
// Self-checking bench; short counts keep the run small
module cpps_top_test;
   import cpps_pkg::*;
   localparam int unsigned DET = 50, OC = 20, STP = 10, DEAD = CPPS_DEAD_CYC; // Shortened intervals; DEAD keeps the full dead time
   logic clock = 0, rst = 1;
   logic [3:0] avs_address = 0, avs_byteenable = 4'hf;
   logic avs_read = 0, avs_write = 0;
   logic [31:0] avs_writedata = 0, avs_readdata, q;
   logic avs_waitrequest, supply_ok = 0, adapter_sense_above_low = 0, adapter_sense_above_det = 0;
   logic supply_above_battery = 0, adapter_side_near_battery, adapter_overvoltage = 0;
   logic thermal_shutdown = 0, thermistor_sense_ok = 1, ratio_reference_ok = 1, input_over_limit = 0;
   logic voltage_adjust_at_regulator = 0, cells_above_high = 0, cells_below_low = 0, charge_enable_n = 0;
   logic bias_partial_en, bias_full_en, gate_drive_regulator_en, reference_en, input_current_monitor_en;
   logic adapter_switch_drive_n, battery_switch_drive_n, adapter_good_n, charge_en, input_power_limiting;
   logic voltage_target_default;
   logic [3:0] charge_current_step;
   logic [2:0] cell_count;
   int err_count = 0, checks_done = 0, n, i, both_off = 0;
   // ==========================================
   // Design and far side
   cpps_top #(.DETECT_CYC(DET), .OC_CYC(OC), .STEP_CYC(STP)) cpps_top_i (.clock, .rst, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .supply_ok,
      .adapter_sense_above_low, .adapter_sense_above_det, .supply_above_battery, .adapter_side_near_battery,
      .adapter_overvoltage, .thermal_shutdown, .thermistor_sense_ok, .ratio_reference_ok, .input_over_limit,
      .voltage_adjust_at_regulator, .cells_above_high, .cells_below_low, .charge_enable_n, .bias_partial_en,
      .bias_full_en, .gate_drive_regulator_en, .reference_en, .input_current_monitor_en,
      .adapter_switch_drive_n, .battery_switch_drive_n, .adapter_good_n, .charge_en, .charge_current_step,
      .input_power_limiting, .cell_count, .voltage_target_default);
   cpps_far_side cpps_far_side_i (.clock, .rst, .adapter_present(adapter_sense_above_det),
      .adapter_side_near_battery);
   always #5 clock = ~clock; // 100 MHz
   // Both switches never on together; also time the dead gap
   always @(posedge clock) begin
      if (!rst) `CHK("break_before_make", 1'b1, adapter_switch_drive_n | battery_switch_drive_n)
      both_off <= (adapter_switch_drive_n === 1'b1 && battery_switch_drive_n === 1'b1) ? both_off + 1 : 0;
   end
   // Hang guard
   initial begin
      repeat (50000) @(posedge clock);
      err_count++;
      wrap_up();
   end
   // ==========================================
   // Helpers
   task automatic wrap_up;
      if (err_count == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : wrap_up
   task automatic cyc(input int k);
      repeat (k) @(posedge clock);
   endtask : cyc
   // One bus cycle; an idle edge first so strobes never reassign in one step
   task automatic avs(input bit wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      `WAITC(avs_waitrequest === 1'b0, 20)
      q = avs_readdata;
      avs_read <= 0;
      avs_write <= 0;
   endtask : avs
   function automatic logic [2:0] cells_exp(input int k);
      return (k == 1) ? 3'h3 : (k == 2) ? 3'h4 : 3'h2;
   endfunction : cells_exp
   function automatic logic [31:0] status_exp(input logic chg, input logic [3:0] st, input logic lim);
      return {19'h0, 1'b1, lim, 3'h4, st, 2'h2, chg, 1'b1};
   endfunction : status_exp
   // Charge ramp from step one to the cap
   task automatic ramp;
      int w, k;
      `WAITC(charge_en === 1'b1, 300)
      `CHK("step_first", 4'h1, charge_current_step)
      for (k = 2; k <= 8; k++) begin
         w = 0;
         while (charge_current_step !== k[3:0] && w < 50) begin @(posedge clock); w++; end
         `CHK("step", k[3:0], charge_current_step)
         `CHK("step_len", 1'b1, (w >= STP && w <= STP + 2))
      end
      cyc(3 * STP);
      `CHK("step_cap", 4'h8, charge_current_step)
   endtask : ramp
   // Fault code: host enable, overvoltage, thermal, thermistor, reference
   task automatic set_fault(input int f, input logic v);
      case (f)
         0: charge_enable_n <= v;
         1: adapter_overvoltage <= v;
         2: thermal_shutdown <= v;
         3: thermistor_sense_ok <= !v;
         default: ratio_reference_ok <= !v;
      endcase
   endtask : set_fault
   // ==========================================
   // Main sequence
   initial begin
      void'($urandom(32'h69598dc5));
      cyc(8);
      rst <= 0;
      cyc(3);
      `CHK("partial_off", 1'b0, bias_partial_en)
      `CHK("good_off", 1'b1, adapter_good_n)
      supply_ok <= 1;
      cyc(3);
      `CHK("partial", 1'b1, bias_partial_en)
      `CHK("full_off", 1'b0, bias_full_en)
      `CHK("monitor_off", 1'b0, input_current_monitor_en)
      `CHK("ac_off", 1'b1, adapter_switch_drive_n)
      `CHK("bat_on", 1'b0, battery_switch_drive_n)
      for (i = 0; i < 3; i++) begin
         cells_above_high <= (i == 2);
         cells_below_low <= (i == 1);
         voltage_adjust_at_regulator <= i[0];
         cyc(3);
         `CHK("cells", cells_exp(i), cell_count)
         `CHK("vtarget", i[0], voltage_target_default)
      end
      adapter_sense_above_low <= 1;
      cyc(3);
      `CHK("full", 1'b1, bias_full_en & gate_drive_regulator_en & reference_en)
      `CHK("monitor", 1'b1, input_current_monitor_en)
      // Adapter valid but no headroom yet; a glitch first must restart the delay
      adapter_sense_above_det <= 1;
      cyc(DET / 2);
      adapter_sense_above_det <= 0;
      cyc(2);
      `CHK("good_early", 1'b1, adapter_good_n)
      adapter_sense_above_det <= 1;
      `WAITC(adapter_good_n === 1'b0, DET + 10)
      `CHK("good_delay", 1'b1, (n >= DET && n <= DET + 3))
      cyc(OC + 20);
      `CHK("hold_bat", 1'b0, battery_switch_drive_n)
      `CHK("no_headroom", 1'b0, charge_en)
      supply_above_battery <= 1;
      ramp();
      `CHK("gap", 2'b11, {adapter_switch_drive_n, battery_switch_drive_n})
      `WAITC(adapter_switch_drive_n === 1'b0, DEAD + 10)
      `CHK("dead_in", 1'b1, (both_off >= DEAD - 1 && both_off <= DEAD + 2))
      for (i = 0; i < 8; i++) begin
         n = (i < 5) ? i : $urandom_range(0, 4);
         set_fault(n, 1'b1);
         cyc(3);
         `CHK("fault_stop", 1'b0, charge_en)
         cyc($urandom_range(1, 20));
         set_fault(n, 1'b0);
         ramp();
      end
      input_over_limit <= 1;
      `WAITC(charge_current_step !== 4'h8, STP + 4)
      `CHK("limiting", 1'b1, input_power_limiting)
      `CHK("step_down", 4'h7, charge_current_step)
      cyc(10 * STP);
      avs(0, 4'h8, 0);
      `CHK("level", 4'h1, q[3:0])
      avs(1, 4'h0, 32'hffff_ffff);
      avs(0, 4'h0, 0);
      `CHK("status", status_exp(1'b1, 4'h1, 1'b1), q)
      avs(0, 4'hc, 0);
      `CHK("unmapped", 32'h0, q)
      avs_byteenable <= 4'he;
      avs(1, 4'h4, 32'h1);
      avs_byteenable <= 4'hf;
      avs(0, 4'h4, 0);
      `CHK("lane_off", 32'h0, q)
      avs(1, 4'h4, 32'h1);
      avs(0, 4'h4, 0);
      `CHK("inhibit", 32'h1, q)
      `CHK("inhibit_stop", 1'b0, charge_en)
      avs(1, 4'h4, 32'h0);
      input_over_limit <= 0;
      ramp();
      // Unplug while charging on the adapter
      adapter_sense_above_det <= 0;
      cyc(3);
      `CHK("good_clear", 1'b1, adapter_good_n)
      `CHK("abort", 1'b0, charge_en)
      cyc(10);
      `CHK("wait_sag", 1'b0, adapter_switch_drive_n)
      `WAITC(battery_switch_drive_n === 1'b0, DEAD + 60)
      `CHK("dead_out", 1'b1, (both_off >= DEAD - 1 && both_off <= DEAD + 2))
      supply_ok <= 0;
      cyc(3);
      `CHK("lockout", 3'h0, {bias_partial_en, bias_full_en, input_current_monitor_en})
      `CHK("lockout_ac", 1'b1, adapter_switch_drive_n)
      wrap_up();
   end
endmodule : cpps_top_test
`default_nettype wire
